/* verilog/pxs_pkg.sv */
// Purpose: Shared constants and carrier types for the index push sequencer.
// Assumes: 16-bit addresses and 8-bit data on the external memory bus.
// Notes: All opcode bytes and widths live here.
package pxs_pkg;

  // ----------------------------------------------------------------
  // Widths and opcodes
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] OPC_PREFIX = 8'hDD;
  localparam logic [7:0] OPC_PUSH = 8'hE5;
  localparam logic [15:0] SP_STEP = 16'h0001;
  localparam logic [15:0] SP_RESET = 16'hFFFF;
  localparam logic [7:0] FLAGS_RESET = 8'hFF;
  localparam logic [15:0] IDX_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } pxs_mem_req_type;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } pxs_byte_type;

  typedef enum logic [2:0] {
    PXS_IDLE = 3'b000,
    PXS_PREFIXED = 3'b001,
    PXS_DEC1 = 3'b010,
    PXS_WR_HI = 3'b011,
    PXS_DEC2 = 3'b100,
    PXS_WR_LO = 3'b101
  } pxs_state_type;

endpackage

/* verilog/pxs_opcode_match.sv */
// Purpose: Registered two-byte opcode recogniser.
// Assumes: One opcode byte per valid cycle.
// Notes: hit_o pulses one cycle after the second byte is taken.
`timescale 1ns/1ps
`default_nettype none
module pxs_opcode_match #(
  parameter logic [7:0] FIRST = 8'hDD,
  parameter logic [7:0] SECOND = 8'hE5
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire pxs_pkg::pxs_byte_type op_i,
  output logic hit_o
);

  logic seen_r;
  logic seen_nxt;
  logic hit_r;
  logic hit_nxt;

  always_comb begin
    seen_nxt = seen_r;
    hit_nxt = 1'b0;
    if (op_i.valid) begin
      hit_nxt = seen_r && (op_i.data == SECOND);
      seen_nxt = (op_i.data == FIRST);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      seen_r <= 1'b0;
      hit_r <= 1'b0;
    end else begin
      seen_r <= seen_nxt;
      hit_r <= hit_nxt;
    end
  end

  assign hit_o = hit_r;

endmodule
`default_nettype wire

/* verilog/pxs_push_index_x.sv */
// Purpose: Executes the push of the first index register onto the memory stack.
// Assumes: Memory accepts one write per cycle with no wait states.
// Notes: Stack pointer, index and flags are held here and exposed as outputs.
//
// Contract
// - Push all sixteen bits of the first index register to the stack.
// - Decrement the stack pointer by one before any write.
// - Write the upper index byte at the once-decremented stack pointer.
// - Decrement the stack pointer again, ending two below the start.
// - Write the lower index byte at the twice-decremented stack pointer.
// - No overflow or wraparound check on the stack pointer.
// - The flag register is left untouched by this push.
`timescale 1ns/1ps
`default_nettype none
module pxs_push_index_x (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire pxs_pkg::pxs_byte_type op_i,
  input wire logic idx_load_i,
  input wire logic [15:0] idx_data_i,
  input wire logic sp_load_i,
  input wire logic [15:0] sp_data_i,
  input wire logic flags_load_i,
  input wire logic [7:0] flags_data_i,
  output pxs_pkg::pxs_mem_req_type mem_o,
  output logic busy_o,
  output logic done_o,
  output logic [15:0] stack_pointer_o,
  output logic [15:0] index_register_first_o,
  output logic [7:0] flags_o
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic hit;

  pxs_opcode_match #(
    .FIRST(pxs_pkg::OPC_PREFIX),
    .SECOND(pxs_pkg::OPC_PUSH)
  ) u_match (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .op_i(op_i),
    .hit_o(hit)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // The recogniser already tracks the prefix byte, so the prefixed code is
  // never entered here; it only falls back to idle if it ever appears.
  // A hit that lands while a push is under way is dropped: queuing it would
  // need a pending flag, and the core never overlaps two pushes anyway.
  pxs_pkg::pxs_state_type state_r;
  pxs_pkg::pxs_state_type state_nxt;
  logic idle;

  assign idle = (state_r == pxs_pkg::PXS_IDLE);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      pxs_pkg::PXS_IDLE: begin
        if (hit) begin
          state_nxt = pxs_pkg::PXS_DEC1;
        end
      end
      pxs_pkg::PXS_PREFIXED: begin
        state_nxt = pxs_pkg::PXS_IDLE;
      end
      pxs_pkg::PXS_DEC1: begin
        state_nxt = pxs_pkg::PXS_WR_HI;
      end
      pxs_pkg::PXS_WR_HI: begin
        state_nxt = pxs_pkg::PXS_DEC2;
      end
      pxs_pkg::PXS_DEC2: begin
        state_nxt = pxs_pkg::PXS_WR_LO;
      end
      pxs_pkg::PXS_WR_LO: begin
        state_nxt = pxs_pkg::PXS_IDLE;
      end
      default: begin
        state_nxt = pxs_pkg::PXS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_r <= pxs_pkg::PXS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Stack pointer, index and flags
  // ----------------------------------------------------------------
  // Loads and decrements never meet: loads need idle, decrements need a push state.
  logic [15:0] stack_pointer_r;
  logic [15:0] stack_pointer_nxt;
  logic [15:0] index_register_first_r;
  logic [15:0] index_register_first_nxt;
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [7:0] index_first_lower_byte_r;
  logic [7:0] index_first_lower_byte_nxt;

  always_comb begin
    stack_pointer_nxt = stack_pointer_r;
    index_register_first_nxt = index_register_first_r;
    // The push states have no write path into the flag register at all.
    flags_nxt = flags_r;
    index_first_lower_byte_nxt = index_first_lower_byte_r;
    // Loads are only taken while idle so the pushed value is stable.
    if (idle) begin
      if (idx_load_i) begin
        index_register_first_nxt = idx_data_i;
      end
      if (sp_load_i) begin
        stack_pointer_nxt = sp_data_i;
      end
      if (flags_load_i) begin
        flags_nxt = flags_data_i;
      end
    end
    // Both decrements wrap freely from 0000 to FFFF; nothing is reported.
    if (state_r == pxs_pkg::PXS_DEC1) begin
      stack_pointer_nxt = stack_pointer_r - pxs_pkg::SP_STEP;
      // The low byte is captured here so the second write cannot see a later load.
      index_first_lower_byte_nxt = index_register_first_r[7:0];
    end
    if (state_r == pxs_pkg::PXS_DEC2) begin
      stack_pointer_nxt = stack_pointer_r - pxs_pkg::SP_STEP;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      stack_pointer_r <= pxs_pkg::SP_RESET;
      index_register_first_r <= pxs_pkg::IDX_RESET;
      flags_r <= pxs_pkg::FLAGS_RESET;
      index_first_lower_byte_r <= '0;
    end else begin
      stack_pointer_r <= stack_pointer_nxt;
      index_register_first_r <= index_register_first_nxt;
      flags_r <= flags_nxt;
      index_first_lower_byte_r <= index_first_lower_byte_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Memory request
  // ----------------------------------------------------------------
  // Each write is a one-cycle pulse; the memory must take it with no wait state.
  pxs_pkg::pxs_mem_req_type mem_r;
  pxs_pkg::pxs_mem_req_type mem_nxt;

  always_comb begin
    mem_nxt = '0;
    // The address holds between writes so the bus does not jump to zero.
    mem_nxt.addr = mem_r.addr;
    if (state_r == pxs_pkg::PXS_WR_HI) begin
      mem_nxt.we = 1'b1;
      mem_nxt.addr = stack_pointer_r;
      mem_nxt.wdata = index_register_first_r[15:8];
    end
    if (state_r == pxs_pkg::PXS_WR_LO) begin
      mem_nxt.we = 1'b1;
      mem_nxt.addr = stack_pointer_r;
      mem_nxt.wdata = index_first_lower_byte_r;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mem_r <= '0;
    end else begin
      mem_r <= mem_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------
  // Done marks the cycle of the low-byte write, so a caller can chain the next push.
  logic busy_r;
  logic busy_nxt;
  logic done_r;
  logic done_nxt;

  always_comb begin
    // Busy drops with the last write, so done and idle are seen together.
    busy_nxt = (state_nxt != pxs_pkg::PXS_IDLE);
    done_nxt = (state_r == pxs_pkg::PXS_WR_LO);
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign mem_o = mem_r;
  assign busy_o = busy_r;
  assign done_o = done_r;
  assign stack_pointer_o = stack_pointer_r;
  assign index_register_first_o = index_register_first_r;
  assign flags_o = flags_r;

endmodule
`default_nettype wire

/* verification/pxs_mem_model.sv */
// Purpose: Byte-wide memory that holds the stack.
// Assumes: No wait states and one write per cycle.
// Notes: Bytes that were never written read as unknown.
`timescale 1ns/1ps
`default_nettype none
module pxs_mem_model (
  input wire logic mclk_i,
  input wire pxs_pkg::pxs_mem_req_type mem_i
);
  logic [7:0] mem [0:65535];
  always @(posedge mclk_i) begin
    if (mem_i.we) begin
      mem[mem_i.addr] <= mem_i.wdata;
    end
  end
endmodule
`default_nettype wire

/* verification/pxs_push_properties.sv */
// Purpose: Timing checks for the index push sequencer.
// Assumes: Most checks are anchored on the rise of busy_o.
// Notes: The bind statement follows the module.
`timescale 1ns/1ps
`default_nettype none
module pxs_push_properties (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire pxs_pkg::pxs_byte_type op_i,
  input wire pxs_pkg::pxs_mem_req_type mem_o,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic [15:0] stack_pointer_o,
  input wire logic [15:0] index_register_first_o,
  input wire logic [7:0] flags_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_start; $rose(busy_o); endsequence
  sequence s_writes; !mem_o.we ##1 !mem_o.we ##1 mem_o.we ##1 !mem_o.we ##1 (mem_o.we && done_o); endsequence
  property p_writes; s_start |-> s_writes; endproperty
  property p_dec1; s_start |=> stack_pointer_o == $past(stack_pointer_o) - 16'h0001; endproperty
  property p_hi; s_start |-> ##2 mem_o.addr == $past(stack_pointer_o, 2) - 16'h0001
    && mem_o.wdata == index_register_first_o[15:8]; endproperty
  property p_dec2; s_start |-> ##3 stack_pointer_o == $past(stack_pointer_o, 3) - 16'h0002; endproperty
  property p_lo; s_start |-> ##4 mem_o.addr == $past(stack_pointer_o, 4) - 16'h0002
    && mem_o.addr == stack_pointer_o && mem_o.wdata == index_register_first_o[7:0];
  endproperty
  property p_wrap; s_start ##0 (stack_pointer_o == 16'h0001) |-> ##1 (stack_pointer_o == 16'h0000)
    ##2 (stack_pointer_o == 16'hFFFF); endproperty
  property p_len; s_start |-> busy_o [*4] ##1 !busy_o; endproperty
  property p_flags; busy_o |=> $stable(flags_o); endproperty
  property p_opc; s_start |-> $past(op_i.valid && op_i.data == 8'hE5, 2); endproperty
  a_writes: assert property (p_writes) else $error("write pattern wrong");
  a_dec1: assert property (p_dec1) else $error("first decrement wrong");
  a_hi: assert property (p_hi) else $error("upper byte write wrong");
  a_dec2: assert property (p_dec2) else $error("second decrement wrong");
  a_lo: assert property (p_lo) else $error("lower byte write wrong");
  a_len: assert property (p_len) else $error("push length wrong");
  a_wrap: assert property (p_wrap) else $error("pointer wrap wrong");
  a_flags: assert property (p_flags) else $error("flags changed");
  a_opc: assert property (p_opc) else $error("push without opcode");
endmodule
bind pxs_push_index_x pxs_push_properties u_chk (
  .mclk_i(mclk_i),
  .rst_i(rst_i),
  .op_i(op_i),
  .mem_o(mem_o),
  .busy_o(busy_o),
  .done_o(done_o),
  .stack_pointer_o(stack_pointer_o),
  .index_register_first_o(index_register_first_o),
  .flags_o(flags_o)
);
`default_nettype wire

/* verification/testbench.sv */
// Purpose: Self-checking bench for the index push sequencer.
// Assumes: The memory model takes every write with no wait states.
// Notes: Each scenario loads state and sends opcodes; all but the broken pair push, then inspect memory.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module testbench;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ld = 1'b0;
  logic busy_o, done_o;
  logic [15:0] sp_d = 16'h0000, x_d = 16'h0000, sp_o, x_o;
  logic [7:0] f_d = 8'h00, flags_o;
  pxs_pkg::pxs_byte_type op_i = '0;
  pxs_pkg::pxs_mem_req_type mem_o;
  int miscompares = 0, n_tests = 0;
  pxs_push_index_x u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .op_i(op_i), .idx_load_i(ld), .idx_data_i(x_d),
    .sp_load_i(ld), .sp_data_i(sp_d), .flags_load_i(ld), .flags_data_i(f_d), .mem_o(mem_o), .busy_o(busy_o),
    .done_o(done_o), .stack_pointer_o(sp_o), .index_register_first_o(x_o), .flags_o(flags_o));
  pxs_mem_model u_mem (.mclk_i(mclk_i), .mem_i(mem_o));
  initial forever #12.5 mclk_i = ~mclk_i;
  task automatic close_out;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic op(input logic [7:0] d, input logic v);
    @(posedge mclk_i);
    op_i <= '{valid: v, data: d};
  endtask
  task automatic load(input logic [15:0] s, input logic [15:0] x, input logic [7:0] f);
    @(posedge mclk_i);
    ld <= 1'b1;
    sp_d <= s;
    x_d <= x;
    f_d <= f;
    @(posedge mclk_i);
    ld <= 1'b0;
  endtask
  // The memory model stores one edge after done_o, so settle waits past it.
  task automatic settle;
    int i;
    for (i = 0; i < 12 && done_o !== 1'b1; i++) @(negedge mclk_i);
    if (i == 12) begin
      miscompares++;
      close_out();
    end
    repeat (2) @(negedge mclk_i);
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] x, input logic [7:0] f);
    `CHK(u_mem.mem[s - 16'h0001], x[15:8])
    `CHK(u_mem.mem[s - 16'h0002], x[7:0])
    `CHK(sp_o, s - 16'h0002)
    `CHK(flags_o, f)
    `CHK(x_o, x)
    $display("test end sp %h", s);
  endtask
  task automatic t_basic;
    load(16'h8000, 16'hA5C3, 8'h5A);
    op(8'hDD, 1'b1);
    op(8'hE5, 1'b1);
    op(8'h00, 1'b0);
    settle();
    chk(16'h8000, 16'hA5C3, 8'h5A);
  endtask
  // An idle cycle sits between the opcode bytes and the pointer wraps below zero.
  task automatic t_wrap;
    load(16'h0001, 16'h1234, 8'h00);
    op(8'hDD, 1'b1);
    op(8'h00, 1'b0);
    op(8'hE5, 1'b1);
    op(8'h00, 1'b0);
    settle();
    chk(16'h0001, 16'h1234, 8'h00);
  endtask
  task automatic t_broken;
    load(16'h4000, 16'h0F0F, 8'h81);
    op(8'hDD, 1'b1);
    op(8'h00, 1'b1);
    op(8'hE5, 1'b1);
    op(8'h00, 1'b0);
    repeat (10) @(negedge mclk_i);
    `CHK(sp_o, 16'h4000)
    $display("test end broken pair");
  endtask
  // A second opcode pair arriving while busy must be dropped.
  task automatic t_busy;
    load(16'h2000, 16'hBEEF, 8'hC3);
    op(8'hDD, 1'b1);
    op(8'hE5, 1'b1);
    op(8'hDD, 1'b1);
    op(8'hE5, 1'b1);
    op(8'h00, 1'b0);
    // These loads land mid-push and must leave pointer, index and flags alone.
    load(16'h7777, 16'h1111, 8'h00);
    settle();
    repeat (8) @(negedge mclk_i);
    chk(16'h2000, 16'hBEEF, 8'hC3);
  endtask
  initial begin
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_basic();
    t_wrap();
    t_broken();
    t_busy();
    close_out();
  end
endmodule
`default_nettype wire
